// ===== verilog/ecbc_top.v
/*
 * Expansion card bus controller: bridges incoming 32-bit backplane
 * transactions to two 16-bit local cycles, holds local-to-backplane
 * cycles pending, decodes ROM and DRAM, refreshes DRAM, arbitrates an
 * external master and gathers interrupts. Registers on Avalon-MM.
 * Assumes request, done, status, external-master and interrupt pins arrive asynchronously and are synchronised here; the
 * backplane transaction engine itself is external and signalled by
 * request/done pins.
 */
`timescale 1ns/1ps
`include "ecbc_regs.vh"
module ecbc_top (
	// Clock and reset
	input  wire        MCLK,
	input  wire        RST,
	// Avalon-MM slave
	input  wire [23:0] AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [15:0] AVS_WRITEDATA,
	output reg  [15:0] AVS_READDATA,
	output wire        AVS_WAITREQUEST,
	// Delayed backplane clock phases
	input  wire        DELAYED_CLOCK_PHASE_A,
	input  wire        DELAYED_CLOCK_PHASE_B,
	output wire        LOCAL_CLK,
	// Incoming backplane request (slave mode)
	input  wire        BP_IN_REQ,
	input  wire [31:0] BP_IN_ADDR,
	input  wire [1:0]  BP_IN_SIZE,
	output reg         BP_IN_ACK,
	// Local processor request to backplane (master mode)
	input  wire        LP_REQ,
	input  wire [1:0]  LP_SIZE,
	output reg         LP_DTACK,
	output reg         LOCAL_BUS_ERROR_N,
	output reg         HALT_N,
	output reg         LP_OFF_BUS,
	// Backplane transaction engine
	output reg         BP_OUT_START,
	input  wire        BP_OUT_DONE,
	input  wire        TRANSFER_STATUS_BIT_LOW,
	input  wire        TRANSFER_STATUS_BIT_HIGH,
	// Local cycle generator
	output reg         LC_START,
	output reg         LC_UPPER_HALF,
	output reg  [1:0]  LC_BYTE_LANES,
	input  wire        LC_DONE,
	// Memory decode
	output reg         ROM_SEL,
	output reg         ID_ROM_SEL,
	output reg         DRAM_SEL,
	output reg         RAS_N,
	output reg         CAS_N,
	output reg  [1:0]  DRAM_ORG,
	// External master arbitration and lines
	input  wire        XM_REQ,
	input  wire        XM_ACK,
	output reg         XM_GRANT,
	output reg  [3:0]  EXTERNAL_MASTER_BUS_OUT,
	output reg  [3:0]  EXTERNAL_MASTER_BUS_OE,
	input  wire [3:0]  EXTERNAL_MASTER_BUS_IN,
	// Interrupt sources and output
	input  wire        BP_IRQ,
	input  wire        IO_PROCESSOR_IRQ,
	input  wire        REMOTE_IO_PROCESSOR_IRQ,
	output reg         LOCAL_IRQ
);
	localparam S_IDLE   = 3'h0;
	localparam S_LO     = 3'h1;
	localparam S_HI     = 3'h2;
	localparam S_ACK    = 3'h3;
	localparam S_MREQ   = 3'h4;
	localparam S_MWAIT  = 3'h5;
	localparam S_MDONE  = 3'h6;
	localparam SZ_32    = 2'h2;
	localparam [31:0] REF_CYC = `ECBC_REFRESH_CYC;

	// Synchronisers for every asynchronous pin except the two clock phases, which ecbc_phase_clk synchronises.
	reg [1:0]  s_inreq_r, s_lpreq_r, s_done_r, s_lcdone_r, s_xreq_r, s_xack_r;
	reg [1:0]  s_tm0_r, s_tm1_r, s_bpirq_r, s_iopirq_r, s_riopirq_r;
	reg [3:0]  s_gpi0_r, s_gpi1_r;
	wire inreq  = s_inreq_r[1];
	wire lpreq  = s_lpreq_r[1];
	wire odone  = s_done_r[1];
	wire lcdone = s_lcdone_r[1];

	always @(posedge MCLK) begin
		if (RST) begin
			s_inreq_r <= 2'h0; s_lpreq_r <= 2'h0; s_done_r <= 2'h0;
			s_lcdone_r <= 2'h0; s_xreq_r <= 2'h0; s_xack_r <= 2'h0;
			s_tm0_r <= 2'h0; s_tm1_r <= 2'h0; s_bpirq_r <= 2'h0;
			s_iopirq_r <= 2'h0; s_riopirq_r <= 2'h0;
			s_gpi0_r <= 4'h0; s_gpi1_r <= 4'h0;
		end else begin
			s_inreq_r <= {s_inreq_r[0], BP_IN_REQ};
			s_lpreq_r <= {s_lpreq_r[0], LP_REQ};
			s_done_r <= {s_done_r[0], BP_OUT_DONE};
			s_lcdone_r <= {s_lcdone_r[0], LC_DONE};
			s_xreq_r <= {s_xreq_r[0], XM_REQ};
			s_xack_r <= {s_xack_r[0], XM_ACK};
			s_tm0_r <= {s_tm0_r[0], TRANSFER_STATUS_BIT_LOW};
			s_tm1_r <= {s_tm1_r[0], TRANSFER_STATUS_BIT_HIGH};
			s_bpirq_r <= {s_bpirq_r[0], BP_IRQ};
			s_iopirq_r <= {s_iopirq_r[0], IO_PROCESSOR_IRQ};
			s_riopirq_r <= {s_riopirq_r[0], REMOTE_IO_PROCESSOR_IRQ};
			s_gpi0_r <= EXTERNAL_MASTER_BUS_IN;
			s_gpi1_r <= s_gpi0_r;
		end
	end

	// Local clock from the phase generator.
	ecbc_phase_clk u_clk (
		.mclk        (MCLK),
		.rst         (RST),
		.phase_a     (DELAYED_CLOCK_PHASE_A),
		.phase_b     (DELAYED_CLOCK_PHASE_B),
		.local_clk_r (LOCAL_CLK)
	);

	// Registers.
	reg [2:0]  state_r;
	reg [15:0] ctrl_r, xbcfg_r, gpio_r, tmrld_r, errstat_r;
	reg [3:0]  intstat_r;
	reg        tmr_load_r;
	reg [3:0]  slot_id_r;
	reg        acc_r;
	wire [15:0] tmr_count;
	wire        tmr_flag;
	wire        tmr_clr = AVS_WRITE && acc_r && (AVS_ADDRESS == `ECBC_OFF_INTSTAT)
		&& AVS_WRITEDATA[0];

	ecbc_down_timer u_tmr (
		.mclk     (MCLK),
		.rst      (RST),
		.enable   (ctrl_r[4]),
		.reload   (tmrld_r),
		.load     (tmr_load_r),
		.flag_clr (tmr_clr),
		.count_r  (tmr_count),
		.flag_r   (tmr_flag)
	);

	// One wait state on every bus access: answer on the second edge.
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !acc_r;

	always @(posedge MCLK) begin
		if (RST) begin
			acc_r <= 1'b0;
			ctrl_r <= `ECBC_CTRL_RST;
			xbcfg_r <= 16'h0000;
			gpio_r <= 16'h0000;
			tmrld_r <= 16'hffff;
			tmr_load_r <= 1'b0;
			intstat_r <= 4'h0;
			AVS_READDATA <= 16'h0000;
			slot_id_r <= `ECBC_SLOT_ID_RST;
		end else begin
			acc_r <= (AVS_READ || AVS_WRITE) && !acc_r;
			tmr_load_r <= 1'b0;
			// Sticky interrupt bits: a new event outranks a write-one clear.
			intstat_r <= (intstat_r & ~((AVS_WRITE && acc_r &&
				AVS_ADDRESS == `ECBC_OFF_INTSTAT) ? AVS_WRITEDATA[3:0] : 4'h0))
				| {s_riopirq_r[1], s_iopirq_r[1], s_bpirq_r[1], tmr_flag};
			// Writes land only at the accepting edge, when waitrequest is low.
			if (AVS_WRITE && acc_r) begin
				case (AVS_ADDRESS)
				`ECBC_OFF_CTRL: begin
					ctrl_r <= AVS_WRITEDATA;
					slot_id_r <= AVS_WRITEDATA[11:8];
				end
				`ECBC_OFF_XBCFG: xbcfg_r <= AVS_WRITEDATA;
				`ECBC_OFF_GPIO: gpio_r <= AVS_WRITEDATA;
				`ECBC_OFF_TMRLD: begin
					tmrld_r <= AVS_WRITEDATA;
					tmr_load_r <= 1'b1;
				end
				default: ;
				endcase
			end
			if (AVS_READ && !acc_r) begin
				case (AVS_ADDRESS)
				`ECBC_OFF_CTRL: AVS_READDATA <= ctrl_r;
				`ECBC_OFF_XBCFG: AVS_READDATA <= xbcfg_r;
				`ECBC_OFF_GPIO: AVS_READDATA <= {gpio_r[15:4], s_gpi1_r};
				`ECBC_OFF_TMRLD: AVS_READDATA <= tmrld_r;
				`ECBC_OFF_INTSTAT: AVS_READDATA <= {12'h000, intstat_r};
				`ECBC_OFF_ERRSTAT: AVS_READDATA <= errstat_r;
				`ECBC_OFF_TMRCNT: AVS_READDATA <= tmr_count;
				default: AVS_READDATA <= 16'h0000;
				endcase
			end
		end
	end

	// External-master lines: arbitration or decode/GPIO by configuration.
	always @(posedge MCLK) begin
		if (RST) begin
			XM_GRANT <= 1'b0;
			EXTERNAL_MASTER_BUS_OUT <= 4'h0;
			EXTERNAL_MASTER_BUS_OE <= 4'h0;
			LOCAL_IRQ <= 1'b0;
			DRAM_ORG <= 2'h0;
		end else begin
			LOCAL_IRQ <= |(intstat_r & ctrl_r[3:0]);
			DRAM_ORG <= ctrl_r[6:5];
			if (xbcfg_r[1:0] == 2'h0) begin
				// Grant only while the bridge is idle; held until the master lets go.
				if (s_xreq_r[1] && state_r == S_IDLE && !inreq && !lpreq)
					XM_GRANT <= 1'b1;
				else if (!s_xreq_r[1] && !s_xack_r[1])
					XM_GRANT <= 1'b0;
				EXTERNAL_MASTER_BUS_OE <= 4'h0;
			end else if (xbcfg_r[1:0] == 2'h1) begin
				XM_GRANT <= 1'b0;
				EXTERNAL_MASTER_BUS_OUT <= gpio_r[3:0];
				EXTERNAL_MASTER_BUS_OE <= xbcfg_r[7:4];
			end else begin
				XM_GRANT <= 1'b0;
				EXTERNAL_MASTER_BUS_OUT <= {3'h0, ROM_SEL | DRAM_SEL};
				EXTERNAL_MASTER_BUS_OE <= 4'hf;
			end
		end
	end

	// DRAM refresh: CAS then RAS, no address driven.
	reg [31:0] ref_cnt_r;
	reg [1:0]  ref_ph_r;
	always @(posedge MCLK) begin
		if (RST) begin
			ref_cnt_r <= 32'h0;
			ref_ph_r <= 2'h0;
			RAS_N <= 1'b1;
			CAS_N <= 1'b1;
		end else begin
			if (ref_cnt_r == REF_CYC - 32'h1) begin
				ref_cnt_r <= 32'h0;
				ref_ph_r <= 2'h1;
			end else
				ref_cnt_r <= ref_cnt_r + 32'h1;
			case (ref_ph_r)
			2'h1: begin
				CAS_N <= 1'b0;
				ref_ph_r <= 2'h2;
			end
			2'h2: begin
				RAS_N <= 1'b0;
				ref_ph_r <= 2'h3;
			end
			2'h3: begin
				RAS_N <= 1'b1;
				CAS_N <= 1'b1;
				ref_ph_r <= 2'h0;
			end
			default: begin
				// Zero-wait access strobes follow the local cycle directly.
				RAS_N <= !(DRAM_SEL && LC_START);
				CAS_N <= !(DRAM_SEL && LC_START);
			end
			endcase
		end
	end

	// Bridge state machine.
	reg       is32_r, rom_w_r;
	// One local cycle in flight; a new start waits for done to drop again.
	reg       lc_busy_r;
	wire id_hit = (BP_IN_ADDR[31:28] == 4'hf) && (BP_IN_ADDR[27:24] == slot_id_r)
		&& (BP_IN_ADDR[23:16] == 8'hff);
	always @(posedge MCLK) begin
		if (RST) begin
			state_r <= S_IDLE;
			is32_r <= 1'b0;
			rom_w_r <= 1'b0;
			lc_busy_r <= 1'b0;
			BP_IN_ACK <= 1'b0;
			LP_DTACK <= 1'b0;
			LOCAL_BUS_ERROR_N <= 1'b1;
			HALT_N <= 1'b1;
			LP_OFF_BUS <= 1'b0;
			BP_OUT_START <= 1'b0;
			LC_START <= 1'b0;
			LC_UPPER_HALF <= 1'b0;
			LC_BYTE_LANES <= 2'h0;
			ROM_SEL <= 1'b0;
			ID_ROM_SEL <= 1'b0;
			DRAM_SEL <= 1'b0;
			errstat_r <= 16'h0000;
		end else begin
			LC_START <= 1'b0;
			BP_OUT_START <= 1'b0;
			case (state_r)
			S_IDLE: begin
				BP_IN_ACK <= 1'b0;
				LP_DTACK <= 1'b0;
				LOCAL_BUS_ERROR_N <= 1'b1;
				HALT_N <= 1'b1;
				if (inreq && !XM_GRANT) begin
					// Incoming traffic wins; a colliding local request retries.
					if (lpreq) begin
						LOCAL_BUS_ERROR_N <= 1'b0;
						HALT_N <= 1'b0;
					end
					LP_OFF_BUS <= 1'b1;
					is32_r <= (BP_IN_SIZE == SZ_32);
					ID_ROM_SEL <= id_hit;
					ROM_SEL <= id_hit || (BP_IN_ADDR[23:20] == 4'hf);
					DRAM_SEL <= !id_hit && (BP_IN_ADDR[23:20] != 4'hf);
					rom_w_r <= 1'b0;
					// An 8-bit ID ROM answers on every other byte lane.
					LC_BYTE_LANES <= (id_hit && ctrl_r[7]) ? 2'h1 : 2'h3;
					LC_UPPER_HALF <= 1'b0;
					state_r <= S_LO;
				end else if (lpreq && !XM_GRANT) begin
					state_r <= S_MREQ;
				end
			end
			S_LO, S_HI: begin
				// ROM gets one extra cycle before the local cycle starts.
				if (ROM_SEL && !rom_w_r)
					rom_w_r <= 1'b1;
				else if (!lc_busy_r && !lcdone) begin
					LC_START <= 1'b1;
					lc_busy_r <= 1'b1;
				end else if (lc_busy_r && lcdone) begin
					lc_busy_r <= 1'b0;
					rom_w_r <= 1'b0;
					if (state_r == S_LO && is32_r) begin
						LC_UPPER_HALF <= 1'b1;
						state_r <= S_HI;
					end else
						state_r <= S_ACK;
				end
			end
			S_ACK: begin
				BP_IN_ACK <= 1'b1;
				if (!inreq) begin
					BP_IN_ACK <= 1'b0;
					LP_OFF_BUS <= 1'b0;
					ROM_SEL <= 1'b0;
					ID_ROM_SEL <= 1'b0;
					DRAM_SEL <= 1'b0;
					state_r <= S_IDLE;
				end
			end
			S_MREQ: begin
				if (LP_SIZE != SZ_32) begin
					BP_OUT_START <= 1'b1;
					state_r <= S_MWAIT;
				end else begin
					LOCAL_BUS_ERROR_N <= 1'b0;
					state_r <= S_MDONE;
				end
			end
			S_MWAIT: begin
				if (odone) begin
					errstat_r[`ECBC_ERR_TM0_BIT] <= s_tm0_r[1];
					errstat_r[`ECBC_ERR_TM1_BIT] <= s_tm1_r[1];
					if (s_tm0_r[1] || s_tm1_r[1])
						LOCAL_BUS_ERROR_N <= 1'b0;
					else
						LP_DTACK <= 1'b1;
					state_r <= S_MDONE;
				end
			end
			S_MDONE: begin
				if (!lpreq) begin
					LP_DTACK <= 1'b0;
					LOCAL_BUS_ERROR_N <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== verilog/ecbc_regs.vh
/*
 * Constants of the expansion card bus controller: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by the top-level design file only; definitions only.
 */
`ifndef ECBC_REGS_VH
`define ECBC_REGS_VH

`define ECBC_ADDR_W        24
`define ECBC_OFF_ERRSTAT   24'hca000a
`define ECBC_OFF_CTRL      24'hca0000
`define ECBC_OFF_XBCFG     24'hca0002
`define ECBC_OFF_GPIO      24'hca0004
`define ECBC_OFF_TMRLD     24'hca0006
`define ECBC_OFF_INTSTAT   24'hca0008
`define ECBC_OFF_TMRCNT    24'hca000c
`define ECBC_CTRL_RST      16'h0000
`define ECBC_ERR_TM0_BIT   6
`define ECBC_ERR_TM1_BIT   7
`define ECBC_CLK_HZ        125000000
`define ECBC_REFRESH_MS    13
`define ECBC_REFRESH_CYC   ((`ECBC_CLK_HZ / 1000) * `ECBC_REFRESH_MS)
`define ECBC_SLOT_ID_RST   4'h9
`define ECBC_ROM_WAIT      1

`endif

// ===== verilog/ecbc_phase_clk.v
/*
 * Local processor clock generator: rebuilds a 10 MHz clock from the two
 * delayed backplane clock phases.
 * Assumes both phases are asynchronous pins sampled on MCLK.
 */
`timescale 1ns/1ps
module ecbc_phase_clk (
	// Clock and reset
	input  wire mclk,
	input  wire rst,
	// Phases
	input  wire phase_a,
	input  wire phase_b,
	// Output
	output reg  local_clk_r
);
	reg [1:0] a_sync_r;
	reg [1:0] b_sync_r;

	always @(posedge mclk) begin
		if (rst) begin
			a_sync_r    <= 2'h0;
			b_sync_r    <= 2'h0;
			local_clk_r <= 1'b0;
		end else begin
			a_sync_r    <= {a_sync_r[0], phase_a};
			b_sync_r    <= {b_sync_r[0], phase_b};
			// Set by phase a, cleared by phase b: one cycle per 10 MHz period.
			if (a_sync_r[1] && !b_sync_r[1])
				local_clk_r <= 1'b1;
			else if (b_sync_r[1] && !a_sync_r[1])
				local_clk_r <= 1'b0;
		end
	end
endmodule

// ===== verilog/ecbc_down_timer.v
/*
 * 16-bit down-counting timer with automatic reload and a sticky
 * terminal-count flag.
 * Assumes the reload value and enable come from the control registers.
 */
`timescale 1ns/1ps
module ecbc_down_timer (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// Control
	input  wire        enable,
	input  wire [15:0] reload,
	input  wire        load,
	input  wire        flag_clr,
	// Status
	output reg  [15:0] count_r,
	output reg         flag_r
);
	wire at_zero = (count_r == 16'h0000);

	always @(posedge mclk) begin
		if (rst) begin
			count_r <= 16'h0000;
			flag_r  <= 1'b0;
		end else begin
			if (load)
				count_r <= reload;
			else if (enable && at_zero)
				count_r <= reload;
			else if (enable)
				count_r <= count_r - 16'h0001;
			// Set wins over a clear in the same cycle.
			if (enable && at_zero && !load)
				flag_r <= 1'b1;
			else if (flag_clr)
				flag_r <= 1'b0;
		end
	end
endmodule

// ===== tb/ecbc_sva.sv
/*
 * Port-level checker for the expansion card bus controller top.
 * Assumes it is bound to ecbc_top and sees that module's ports only.
 */
`timescale 1ns/1ps
module ecbc_sva (
	// Clock and reset
	input wire       MCLK,
	input wire       RST,
	// Register bus
	input wire       AVS_READ,
	input wire       AVS_WRITE,
	input wire       AVS_WAITREQUEST,
	// Incoming and outgoing backplane
	input wire       BP_IN_REQ,
	input wire [1:0] BP_IN_SIZE,
	input wire       BP_IN_ACK,
	input wire [1:0] LP_SIZE,
	input wire       LP_DTACK,
	input wire       LOCAL_BUS_ERROR_N,
	input wire       HALT_N,
	input wire       LP_OFF_BUS,
	input wire       BP_OUT_START,
	input wire       LC_START
);
	reg [1:0] halves_r;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	// Local cycles started for the incoming access now open.
	always @(posedge MCLK) begin
		if (RST || !BP_IN_REQ)
			halves_r <= 2'h0;
		else if (LC_START && halves_r != 2'h3)
			halves_r <= halves_r + 2'h1;
	end

	a_avs_wait: assert property ($rose(AVS_READ || AVS_WRITE) |->
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("waitrequest timing wrong");
	a_start_pulse: assert property (BP_OUT_START |=> !BP_OUT_START)
		else $error("backplane start longer than one cycle");
	a_half_pulse: assert property (LC_START |=> !LC_START)
		else $error("local start longer than one cycle");
	a_ack_halves: assert property ($rose(BP_IN_ACK) |->
		halves_r == ((BP_IN_SIZE == 2'h2) ? 2'h2 : 2'h1)) else $error("ack before halves done");
	a_ack_hold: assert property (BP_IN_ACK && BP_IN_REQ |=> BP_IN_ACK)
		else $error("ack dropped while request high");
	a_off_bus: assert property (LC_START |-> LP_OFF_BUS)
		else $error("processor on bus during incoming access");
	a_dtack_err: assert property (!(LP_DTACK && !LOCAL_BUS_ERROR_N))
		else $error("dtack and bus error together");
	a_no_wide: assert property (BP_OUT_START |-> LP_SIZE != 2'h2)
		else $error("wide local transfer started");
	a_halt_pair: assert property (!HALT_N |-> !LOCAL_BUS_ERROR_N)
		else $error("halt without bus error");
endmodule

bind ecbc_top ecbc_sva i_ecbc_sva (.MCLK(MCLK), .RST(RST), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .BP_IN_REQ(BP_IN_REQ),
	.BP_IN_SIZE(BP_IN_SIZE), .BP_IN_ACK(BP_IN_ACK), .LP_SIZE(LP_SIZE), .LP_DTACK(LP_DTACK),
	.LOCAL_BUS_ERROR_N(LOCAL_BUS_ERROR_N), .HALT_N(HALT_N), .LP_OFF_BUS(LP_OFF_BUS),
	.BP_OUT_START(BP_OUT_START), .LC_START(LC_START));

// ===== tb/ecbc_far_end.sv
/*
 * Far-side model: local cycle generator and backplane transaction engine.
 * Assumes the bench sets the answer latency and the transfer status code.
 */
`timescale 1ns/1ps
module ecbc_far_end (
	// Clock
	input  wire       mclk,
	// Bench settings
	input  wire [3:0] lat,
	input  wire [1:0] tm_set,
	// Local cycle handshake
	input  wire       lc_start,
	output reg        lc_done,
	// Backplane engine handshake
	output reg        bp_out_done,
	output reg        tm_low,
	output reg        tm_high,
	input  wire       bp_out_start
);
	reg [4:0] lc_c = 5'h00;
	reg [4:0] bp_c = 5'h00;
	reg       fin;

	initial begin
		lc_done = 1'b0;
		bp_out_done = 1'b0;
		tm_low = 1'b1;
		tm_high = 1'b1;
	end

	// Done stands four cycles so the synchronised copy is seen, then drops
	// before the next half; status lines show the inverse outside done.
	always @(posedge mclk) begin
		lc_c <= lc_start ? {1'b0, lat} + 5'h04 : lc_c - (lc_c != 5'h00);
		lc_done <= lc_c != 5'h00 && lc_c <= 5'h04;
		bp_c <= bp_out_start ? {1'b0, lat} + 5'h04 : bp_c - (bp_c != 5'h00);
		fin = bp_c != 5'h00 && bp_c <= 5'h04;
		bp_out_done <= fin;
		tm_low <= fin ? tm_set[0] : ~tm_set[0];
		tm_high <= fin ? tm_set[1] : ~tm_set[1];
	end
endmodule

// ===== tb/testbench.sv
/*
 * Self-checking bench for the expansion card bus controller.
 * Assumes the far-side model answers local cycles and backplane starts.
 */
`timescale 1ns/1ps
module testbench;
	reg         mclk, rst = 1, avs_read = 0, avs_write = 0, bp_in_req = 0, lp_req = 0;
	reg         pa = 0, pb = 0, xm_req = 0, xm_ack = 0, lclk_d = 0;
	reg  [23:0] avs_address = 0;
	reg  [15:0] avs_writedata = 0;
	reg  [31:0] bp_in_addr = 0;
	reg  [1:0]  bp_in_size = 0, lp_size = 0, tm_set = 0;
	reg  [3:0]  lat = 4'h1;
	reg  [4:0]  ph_c = 5'h00;
	wire [15:0] avs_readdata;
	wire [3:0]  xm_out, xm_oe;
	wire [1:0]  dram_org, lc_lanes;
	wire        avs_wait, local_clk, bp_in_ack, lp_dtack, lbe_n, halt_n, lc_start, lc_upper;
	wire        bp_out_start, bp_out_done, tm_low, tm_high, lc_done, id_rom_sel, ras_n, cas_n;
	wire        xm_grant;
	integer     error_cnt = 0, n_tests = 0, cyc = 0, lclk_n = 0, lc_n = 0, up_n = 0;
	integer     id_n = 0, st_n = 0;

	ecbc_top i_ecbc_top (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_wait),
		.DELAYED_CLOCK_PHASE_A(pa), .DELAYED_CLOCK_PHASE_B(pb), .LOCAL_CLK(local_clk),
		.BP_IN_REQ(bp_in_req), .BP_IN_ADDR(bp_in_addr), .BP_IN_SIZE(bp_in_size),
		.BP_IN_ACK(bp_in_ack), .LP_REQ(lp_req), .LP_SIZE(lp_size), .LP_DTACK(lp_dtack),
		.LOCAL_BUS_ERROR_N(lbe_n), .HALT_N(halt_n), .LP_OFF_BUS(),
		.BP_OUT_START(bp_out_start), .BP_OUT_DONE(bp_out_done),
		.TRANSFER_STATUS_BIT_LOW(tm_low), .TRANSFER_STATUS_BIT_HIGH(tm_high),
		.LC_START(lc_start), .LC_UPPER_HALF(lc_upper), .LC_BYTE_LANES(lc_lanes),
		.LC_DONE(lc_done), .ROM_SEL(), .ID_ROM_SEL(id_rom_sel), .DRAM_SEL(), .RAS_N(ras_n),
		.CAS_N(cas_n), .DRAM_ORG(dram_org), .XM_REQ(xm_req), .XM_ACK(xm_ack),
		.XM_GRANT(xm_grant), .EXTERNAL_MASTER_BUS_OUT(xm_out), .EXTERNAL_MASTER_BUS_OE(xm_oe),
		.EXTERNAL_MASTER_BUS_IN(4'h0), .BP_IRQ(1'b0), .IO_PROCESSOR_IRQ(1'b0),
		.REMOTE_IO_PROCESSOR_IRQ(1'b0), .LOCAL_IRQ());

	ecbc_far_end i_ecbc_far_end (.mclk(mclk), .lat(lat), .tm_set(tm_set),
		.lc_start(lc_start), .lc_done(lc_done), .bp_out_done(bp_out_done),
		.tm_low(tm_low), .tm_high(tm_high), .bp_out_start(bp_out_start));

	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end

	// Phases alternate 12 and 13 cycle periods, averaging 10 MHz.
	always @(posedge mclk) begin
		ph_c <= (ph_c == 5'h18) ? 5'h00 : ph_c + 5'h01;
		pa <= ph_c < 5'h06 || (ph_c >= 5'h0c && ph_c < 5'h12);
		pb <= (ph_c >= 5'h03 && ph_c < 5'h09) || (ph_c >= 5'h0f && ph_c < 5'h15);
		cyc <= cyc + 1;
		lclk_d <= local_clk;
		lclk_n <= lclk_n + (local_clk && !lclk_d);
		lc_n <= lc_n + lc_start;
		up_n <= up_n + (lc_start && lc_upper);
		id_n <= id_n + id_rom_sel;
		st_n <= st_n + bp_out_start;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			end_sim;
		end
	end

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
			end
		end
	endtask

	task bus(input w, input [23:0] a, input [15:0] wd, output [15:0] d);
		begin
			@(posedge mclk);
			avs_address <= a;
			avs_write <= w;
			avs_read <= !w;
			avs_writedata <= wd;
			@(posedge mclk);
			while (avs_wait !== 1'b0) @(posedge mclk);
			d = avs_readdata;
			avs_read <= 0;
			avs_write <= 0;
		end
	endtask

	task wr(input [23:0] a, input [15:0] wd);
		reg [15:0] d;
		bus(1, a, wd, d);
	endtask

	task t_regs;
		reg [15:0] d;
		integer i;
		begin
			chk({lbe_n, halt_n, ras_n, cas_n}, 4'hf);
			bus(0, 24'hca0000, 0, d);
			chk(d, 0);
			for (i = 1; i < 4; i = i + 1) begin
				wr(24'hca0000, {9'h009, i[1:0], 5'h00});
				repeat (2) @(posedge mclk);
				chk(dram_org, i);
			end
			bus(0, 24'hca00fe, 0, d);
			chk(d, 0);
			wr(24'hca0002, 16'h00f1);
			wr(24'hca0004, 16'h000a);
			repeat (2) @(negedge mclk);
			chk({xm_oe, xm_out}, 8'hfa);
			wr(24'hca0002, 0);
			wr(24'hca0006, 16'h0010);
			wr(24'hca0000, 16'h0910);
			repeat (40) @(posedge mclk);
			bus(0, 24'hca0008, 0, d);
			chk(d[0], 1);
			wr(24'hca0000, 16'h0900);
			i = lclk_n;
			repeat (1000) @(posedge mclk);
			chk(lclk_n - i >= 79 && lclk_n - i <= 81, 1);
		end
	endtask

	task inc(input [31:0] a, input [1:0] sz, input [3:0] dl);
		integer n0, u0, i0;
		begin
			n0 = lc_n;
			u0 = up_n;
			i0 = id_n;
			@(posedge mclk);
			lat <= dl;
			bp_in_addr <= a;
			bp_in_size <= sz;
			bp_in_req <= 1;
			while (bp_in_ack !== 1'b1) @(negedge mclk);
			chk(lc_n - n0, (sz == 2'h2) ? 2 : 1);
			if (sz == 2'h2) chk(up_n - u0, 1);
			chk(lc_lanes, 2'h3);
			chk(id_n > i0, a[31:24] == 8'hf9);
			@(posedge mclk);
			bp_in_req <= 0;
			while (bp_in_ack !== 1'b0) @(negedge mclk);
		end
	endtask

	task out(input [1:0] sz, input [1:0] tm, input e);
		integer s0;
		reg [15:0] d;
		begin
			s0 = st_n;
			@(posedge mclk);
			tm_set <= tm;
			lp_size <= sz;
			lp_req <= 1;
			while (lp_dtack !== 1'b1 && lbe_n !== 1'b0) @(negedge mclk);
			chk(st_n - s0, sz != 2'h2);
			chk({!lbe_n, lp_dtack}, {e, !e});
			@(posedge mclk);
			lp_req <= 0;
			while (lp_dtack !== 1'b0 || lbe_n !== 1'b1) @(negedge mclk);
			wr(24'hca000a, 16'hffff);
			bus(0, 24'hca000a, 0, d);
			if (sz != 2'h2) chk(d[7:6], tm);
		end
	endtask

	task t_clash;
		integer i, h;
		begin
			h = 0;
			@(posedge mclk);
			bp_in_addr <= 32'h00000100;
			bp_in_size <= 2'h1;
			bp_in_req <= 1;
			lp_size <= 2'h1;
			lp_req <= 1;
			for (i = 0; i < 40; i = i + 1) begin
				@(negedge mclk);
				h = h | (halt_n === 1'b0 && lbe_n === 1'b0);
			end
			chk(h, 1);
			@(posedge mclk);
			lp_req <= 0;
			while (bp_in_ack !== 1'b1) @(negedge mclk);
			@(posedge mclk);
			bp_in_req <= 0;
			repeat (20) @(posedge mclk);
		end
	endtask

	task t_xm;
		integer i;
		begin
			@(posedge mclk);
			xm_req <= 1;
			for (i = 0; i < 50 && xm_grant !== 1'b1; i = i + 1) @(negedge mclk);
			chk(xm_grant, 1);
			@(posedge mclk);
			xm_ack <= 1;
			xm_req <= 0;
			repeat (10) @(posedge mclk);
			xm_ack <= 0;
			repeat (10) @(negedge mclk);
			chk(xm_grant, 0);
		end
	endtask

	task end_sim;
		begin
			$display("errors %0d checks %0d", error_cnt, n_tests);
			if (error_cnt == 0 && n_tests > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	initial begin : main
		integer i;
		repeat (8) @(posedge mclk);
		rst <= 0;
		@(negedge mclk);
		t_regs;
		inc(32'hf9fffffc, 2'h0, 4'h1);
		inc(32'hf9fffffc, 2'h2, 4'h9);
		inc(32'h00000100, 2'h1, 4'h1);
		inc(32'h00000200, 2'h2, 4'h1);
		for (i = 0; i < 4; i = i + 1) out({1'b0, i[0]}, i[1:0], i != 0);
		out(2'h2, 2'h0, 1);
		t_clash;
		t_xm;
		end_sim;
	end
endmodule
